// ### srs_pkg.sv
// Functional notes
// - Startup runs either after the external reset pin is released or, with the pin idle, after the internal power-up reset ends.
// - The global reset is held while either the reset pin or the power-up reset is active and ends with the later release.
// - The power-up reset lasts typically 3 ms after the core supply is good and may end as early as 1.5 ms.
// - Where the variant has it, the clock-request output rises about 120 us after reset release.
// - After reset release the chip stays asleep for at least 4.2 ms in either startup case.
// - With no external reference oscillator fitted, the reference comes from a crystal on the two crystal pins.
// - With no toggling on the slow clock input, the internal slow oscillator is used instead.
package srs_pkg;
   localparam int  CLK_MHZ        = 200;
   localparam int  POR_TYP_US     = 3000;
   localparam int  POR_MIN_US     = 1500;
   localparam int  CLKREQ_US      = 120;
   localparam int  SLEEP_MIN_US   = 4200;
   localparam int  AUTOBAUD_MS    = 50;
   localparam int  POR_CYC        = POR_TYP_US * CLK_MHZ;
   localparam int  POR_MIN_CYC    = POR_MIN_US * CLK_MHZ;
   localparam int  CLKREQ_CYC     = CLKREQ_US * CLK_MHZ;
   localparam int  SLEEP_CYC      = SLEEP_MIN_US * CLK_MHZ;
   localparam int  AUTOBAUD_CYC   = AUTOBAUD_MS * 1000 * CLK_MHZ;
   localparam int  LPO_WIN_CYC    = 4096;
   localparam int  CNT_W          = 24;
   typedef enum logic [2:0] {
      SRS_RESET = 3'h0,
      SRS_SLEEP = 3'h1,
      SRS_CHECK = 3'h2,
      SRS_RUN   = 3'h3
   } srs_state_t;
endpackage

// ### srs_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module srs_edge_detect #(
   parameter int WIN_CYC = 4096
) (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic enable_in,
   input  wire logic sig_in,
   output var  logic seen_out
);
   logic [2:0]  sync_q, sync_d;
   logic        seen_q, seen_d;
   // sync_q[0] only feeds sync_q[1]
   always_comb begin
      sync_d = {sync_q[1:0], sig_in};
      seen_d = seen_q;
      if (!enable_in) begin
         seen_d = 1'b0;
      end else if (sync_q[2] != sync_q[1]) begin
         seen_d = 1'b1;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync_q <= 3'h0;
         seen_q <= 1'b0;
      end else begin
         sync_q <= sync_d;
         seen_q <= seen_d;
      end
   end
   assign seen_out = seen_q;
endmodule
`default_nettype wire

// ### srs_top.sv
`timescale 1ns/1ps
`default_nettype none
module srs_top #(
   parameter int POR_CYC      = srs_pkg::POR_CYC,
   parameter int POR_MIN_CYC  = srs_pkg::POR_MIN_CYC,
   parameter int CLKREQ_CYC   = srs_pkg::CLKREQ_CYC,
   parameter int SLEEP_CYC    = srs_pkg::SLEEP_CYC,
   parameter int AUTOBAUD_CYC = srs_pkg::AUTOBAUD_CYC,
   parameter bit HAS_CLKREQ   = 1'b1
) (
   // clock and reset
   input  wire logic mclk_in,
   input  wire logic reset_n_in,
   // board side
   input  wire logic ext_reset_n_in,
   input  wire logic core_supply_good_in,
   input  wire logic ref_osc_present_in,
   input  wire logic slow_clock_input_in,
   input  wire logic uart_flow_in_n_in,
   // startup outputs
   output var  logic global_reset_n_out,
   output var  logic clk_req_out,
   output var  logic asleep_out,
   output var  logic startup_done_out,
   output var  logic use_crystal_out,
   output var  logic use_slow_oscillator_out,
   output var  logic autobaud_req_out
);
   logic [1:0]  rst_sync_q;
   logic        rst_n;
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // pin and supply synchronisers, stage one feeds stage two only
   logic [1:0]  pin_q, pin_d, sup_q, sup_d;
   logic [31:0] por_q, por_d;
   logic        por_act_q, por_act_d;
   logic        grst_q, grst_d;
   always_comb begin
      pin_d     = {pin_q[0], ext_reset_n_in};
      sup_d     = {sup_q[0], core_supply_good_in};
      por_d     = por_q;
      por_act_d = por_act_q;
      if (!sup_q[1]) begin
         por_d     = 32'h0;
         por_act_d = 1'b1;
      end else if (por_act_q) begin
         // release at typical figure, never before the minimum
         if (por_q >= 32'(POR_CYC - 1) && por_q >= 32'(POR_MIN_CYC - 1)) begin
            por_act_d = 1'b0;
         end else begin
            por_d = por_q + 32'h1;
         end
      end
      grst_d = pin_q[1] & ~por_act_q;
   end
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         pin_q     <= 2'h0;
         sup_q     <= 2'h0;
         por_q     <= 32'h0;
         por_act_q <= 1'b1;
         grst_q    <= 1'b0;
      end else begin
         pin_q     <= pin_d;
         sup_q     <= sup_d;
         por_q     <= por_d;
         por_act_q <= por_act_d;
         grst_q    <= grst_d;
      end
   end

   // startup sequence
   srs_pkg::srs_state_t st_q, st_d;
   logic [31:0] tmr_q, tmr_d;
   logic        creq_q, creq_d;
   logic        done_q, done_d;
   logic        xtal_q, xtal_d;
   logic        slowint_q, slowint_d;
   logic        abaud_q, abaud_d;
   logic        lpo_seen;
   srs_edge_detect #(
      .WIN_CYC (srs_pkg::LPO_WIN_CYC)
   ) u_lpo (
      .clk_in    (mclk_in),
      .rst_n_in  (rst_n),
      .enable_in (st_q == srs_pkg::SRS_CHECK),
      .sig_in    (slow_clock_input_in),
      .seen_out  (lpo_seen)
   );
   always_comb begin
      st_d      = st_q;
      tmr_d     = tmr_q;
      creq_d    = creq_q;
      done_d    = done_q;
      xtal_d    = xtal_q;
      slowint_d = slowint_q;
      abaud_d   = abaud_q;
      case (st_q)
         srs_pkg::SRS_RESET: begin
            tmr_d = 32'h0;
            if (grst_q) begin
               st_d = srs_pkg::SRS_SLEEP;
            end
         end
         srs_pkg::SRS_SLEEP: begin
            tmr_d = tmr_q + 32'h1;
            if (HAS_CLKREQ && tmr_q == 32'(CLKREQ_CYC - 1)) begin
               creq_d = 1'b1;
            end
            // external clocks are taken as steady from here on
            if (tmr_q >= 32'(SLEEP_CYC - 1)) begin
               st_d   = srs_pkg::SRS_CHECK;
               xtal_d = ~ref_osc_present_in;
            end
         end
         srs_pkg::SRS_CHECK: begin
            tmr_d = tmr_q + 32'h1;
            if (lpo_seen) begin
               slowint_d = 1'b0;
               st_d      = srs_pkg::SRS_RUN;
               done_d    = 1'b1;
            end else if (tmr_q >= 32'(SLEEP_CYC + srs_pkg::LPO_WIN_CYC - 1)) begin
               slowint_d = 1'b1;
               st_d      = srs_pkg::SRS_RUN;
               done_d    = 1'b1;
            end
         end
         srs_pkg::SRS_RUN: begin
            if (tmr_q < 32'(AUTOBAUD_CYC)) begin
               tmr_d = tmr_q + 32'h1;
               // low flow-control too early selects autobaud
               if (!uart_flow_in_n_in) begin
                  abaud_d = 1'b1;
               end
            end
         end
         default: st_d = srs_pkg::SRS_RESET;
      endcase
      if (!grst_q) begin
         st_d    = srs_pkg::SRS_RESET;
         creq_d  = 1'b0;
         done_d  = 1'b0;
         abaud_d = 1'b0;
      end
   end
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         st_q      <= srs_pkg::SRS_RESET;
         tmr_q     <= 32'h0;
         creq_q    <= 1'b0;
         done_q    <= 1'b0;
         xtal_q    <= 1'b0;
         slowint_q <= 1'b0;
         abaud_q   <= 1'b0;
      end else begin
         st_q      <= st_d;
         tmr_q     <= tmr_d;
         creq_q    <= creq_d;
         done_q    <= done_d;
         xtal_q    <= xtal_d;
         slowint_q <= slowint_d;
         abaud_q   <= abaud_d;
      end
   end

   // outputs registered
   logic asleep_q;
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         asleep_q <= 1'b0;
      end else begin
         asleep_q <= (st_d == srs_pkg::SRS_SLEEP);
      end
   end
   assign global_reset_n_out      = grst_q;
   assign clk_req_out             = creq_q;
   assign asleep_out              = asleep_q;
   assign startup_done_out        = done_q;
   assign use_crystal_out         = xtal_q;
   assign use_slow_oscillator_out = slowint_q;
   assign autobaud_req_out        = abaud_q;
endmodule
`default_nettype wire

// ### srs_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module srs_top_monitor (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic ext_reset_n_in,
   input wire logic ref_osc_present_in,
   input wire logic global_reset_n_out,
   input wire logic clk_req_out,
   input wire logic asleep_out,
   input wire logic startup_done_out,
   input wire logic use_crystal_out,
   input wire logic use_slow_oscillator_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);
   // cycles from sleep end to startup done, saturating so a hang cannot wrap
   logic [12:0] wait_q, wait_d;
   always_comb begin
      wait_d = 13'h0;
      if (global_reset_n_out && !asleep_out && !startup_done_out) begin
         wait_d = (wait_q == 13'h1FFF) ? wait_q : wait_q + 13'h1;
      end
   end
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wait_q <= 13'h0;
      end else begin
         wait_q <= wait_d;
      end
   end
   AST_PIN_HOLD: assert property (!ext_reset_n_in [*4] |-> !global_reset_n_out)
      else $error("reset pin low but chip out of reset");
   AST_PIN_SYNC: assert property (!ext_reset_n_in [*3] ##1 ext_reset_n_in |-> !global_reset_n_out [*3])
      else $error("reset pin passed without synchroniser");
   AST_IDLE: assert property (!global_reset_n_out ##1 !global_reset_n_out
      |-> !asleep_out && !startup_done_out && !clk_req_out)
      else $error("startup outputs active in reset");
   AST_CLKREQ: assert property ($rose(global_reset_n_out) |-> !clk_req_out [*6] ##1 clk_req_out)
      else $error("clock request timing wrong");
   AST_SLEEP: assert property ($rose(global_reset_n_out) |=> asleep_out ##59 asleep_out ##1 !asleep_out)
      else $error("sleep period wrong");
   AST_DONE: assert property (wait_q <= 13'h1004)
      else $error("slow clock check never ended");
   AST_NO_SLOW: assert property ($rose(startup_done_out) && wait_q > 13'h00A
      |-> use_slow_oscillator_out && wait_q >= 13'hFA0)
      else $error("missing slow clock not replaced");
   AST_CRYSTAL: assert property ($rose(startup_done_out) |-> use_crystal_out == !ref_osc_present_in)
      else $error("crystal choice wrong");
endmodule
bind srs_top srs_top_monitor mon (.*);
`default_nettype wire

// ### srs_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module srs_board_model (
   input  wire logic clk_in,
   input  wire logic slow_on_in,
   input  wire logic flow_low_in,
   output var  logic slow_clk_out,
   output var  logic flow_n_out
);
   logic [1:0] div_q = 2'h0;
   initial slow_clk_out = 1'b0;
   // slow clock stands still when absent, runs before sleep ends
   always @(posedge clk_in) if (slow_on_in) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) slow_clk_out <= ~slow_clk_out;
   end
   // host holds flow-control high unless a test breaks the rule on purpose
   assign flow_n_out = ~flow_low_in;
endmodule
`default_nettype wire

// ### test_startup_reset_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_startup_reset_sequencer;
   // shortened timing, the power-up floor kept below the typical figure
   localparam int T_POR     = 40;
   localparam int T_POR_MIN = 20;
   localparam int T_CREQ    = 5;
   localparam int T_SLEEP   = 60;
   localparam int T_ABAUD   = 100;
   localparam int T_WIN     = srs_pkg::LPO_WIN_CYC;
   logic clk, rst_n, pin_n, ref_p, slow_on, slow_clk, flow_low, flow_n;
   logic glob_n, clk_req, asleep, done, use_x, use_s, abaud;
   int   n_fail = 0, n_compared = 0;
   srs_board_model board (.clk_in(clk), .slow_on_in(slow_on), .flow_low_in(flow_low),
      .slow_clk_out(slow_clk), .flow_n_out(flow_n));
   srs_top #(.POR_CYC(T_POR), .POR_MIN_CYC(T_POR_MIN), .CLKREQ_CYC(T_CREQ),
      .SLEEP_CYC(T_SLEEP), .AUTOBAUD_CYC(T_ABAUD)) dut (
      .mclk_in(clk), .reset_n_in(rst_n), .ext_reset_n_in(pin_n),
      .core_supply_good_in(1'b1), .ref_osc_present_in(ref_p),
      .slow_clock_input_in(slow_clk), .uart_flow_in_n_in(flow_n),
      .global_reset_n_out(glob_n), .clk_req_out(clk_req), .asleep_out(asleep),
      .startup_done_out(done), .use_crystal_out(use_x),
      .use_slow_oscillator_out(use_s), .autobaud_req_out(abaud));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic stop_test();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic cmp(input logic got, input logic exp, input string m);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // waits for release, then walks the startup sequence
   task automatic walk(input logic xc, input logic xs, output int n);
      int i;
      n = 0;
      i = 0;
      while (glob_n !== 1'b1 && n < 2000) begin tick(1); n++; end
      if (n >= 2000) begin cmp(1'b0, 1'b1, "no release"); stop_test(); end
      tick(T_CREQ);
      cmp(clk_req, 1'b0, "clock request early");
      tick(1);
      cmp(clk_req, 1'b1, "clock request late");
      tick(T_SLEEP - T_CREQ - 1);
      cmp(asleep, 1'b1, "sleep too short");
      tick(1);
      cmp(asleep, 1'b0, "sleep too long");
      while (i < T_WIN + 16 && done !== 1'b1) begin tick(1); i++; end
      cmp(done, 1'b1, "startup not done");
      cmp(xs ? (i == T_WIN) : (i < 16), 1'b1, "slow clock check length");
      cmp(use_x, xc, "crystal choice");
      cmp(use_s, xs, "slow oscillator choice");
      cmp(abaud, 1'b0, "autobaud without cause");
   endtask
   task automatic s_power_up();
      int n;
      walk(1'b0, 1'b0, n);
      cmp(n >= T_POR_MIN, 1'b1, "power-up reset too short");
      cmp(n >= T_POR && n <= T_POR + 6, 1'b1, "power-up reset length");
      // flow-control low inside the window must be flagged
      flow_low = 1'b1;
      tick(2);
      cmp(abaud, 1'b1, "early flow-control low missed");
      flow_low = 1'b0;
   endtask
   // pin path, with no oscillator and a still slow clock
   task automatic s_pin();
      int n;
      pin_n = 1'b0;
      ref_p = 1'b0;
      slow_on = 1'b0;
      tick(10);
      cmp(glob_n, 1'b0, "pin did not reset");
      cmp(abaud, 1'b0, "autobaud kept over reset");
      pin_n = 1'b1;
      tick(2);
      cmp(glob_n, 1'b0, "pin not synchronised");
      walk(1'b1, 1'b1, n);
      cmp(n == 1, 1'b1, "pin release late");
      // window long over, a low flow-control is ignored
      flow_low = 1'b1;
      tick(2);
      cmp(abaud, 1'b0, "late flow-control low taken");
      flow_low = 1'b0;
   endtask
   initial begin
      rst_n = 1'b0;
      pin_n = 1'b1;
      flow_low = 1'b0;
      ref_p = 1'b1;
      slow_on = 1'b1;
      tick(6);
      rst_n = 1'b1;
      s_power_up();
      s_pin();
      stop_test();
   end
endmodule
`default_nettype wire
